// file: rtl/nvm_defines.svh
// Constants of the nonvolatile self-write controller
// What this block does
// - Write starts only after 55h, AAh, start
// - Start bit refused while write enable clear
// - Hardware never clears the write enable bit
// - Started cycle runs on despite enable clearing
// - Data write end clears start, sets done
// - Program read uses second cycle, squashes it
// - Read data held until next read/write
// - Program-space start handled per variant parameter
// - Program write only in unprotected segments
// - Program blocks are eight aligned words
// - Block write erases sixteen, programs eight
// - Word 111 commits buffer, others only fill
// - Two setup cycles follow program start
// - Buffer fills instant; erase stalls core 4ms
// - Core resumes at third instruction after start
// - Program select clear after reset
// - Read/start bits only set by software
`ifndef NVM_DEFINES_SVH
`define NVM_DEFINES_SVH
// ----------------------------------------------------------------
// Register offsets on the plain register port
// ----------------------------------------------------------------
`define NVM_OFF_ADDR_LOW  3'h0
`define NVM_OFF_ADDR_HIGH 3'h1
`define NVM_OFF_DATA_LOW  3'h2
`define NVM_OFF_DATA_HIGH 3'h3
`define NVM_OFF_CONTROL   3'h4
`define NVM_OFF_UNLOCK    3'h5
`define NVM_OFF_STATUS    3'h6
// ----------------------------------------------------------------
// Field positions and values
// ----------------------------------------------------------------
`define NVM_BIT_PGD   7
`define NVM_BIT_WRITE_ENABLE_BIT  2
`define NVM_BIT_WR    1
`define NVM_BIT_RD    0
`define NVM_BIT_DONE  0
`define NVM_KEY_FIRST  8'h55
`define NVM_KEY_SECOND 8'hAA
`define NVM_BLOCK_LAST 3'h7
`define NVM_RST_BYTE   8'h00
// Self-write protection limits (word addresses)
`define NVM_PROT_LIMIT_LOW 13'h0100
`define NVM_PROT_LIMIT_MID 13'h0800
// ----------------------------------------------------------------
// Timing
// ----------------------------------------------------------------
`define NVM_CLK_MHZ          125
`define NVM_ERASE_TIME_US    4000
`define NVM_EE_WRITE_TIME_US 4000
`define NVM_SETUP_CYC        19'h00002
`define NVM_CNT_W            19
`endif

// file: rtl/nvm_pkg.sv
// Types shared by the nonvolatile self-write controller
package nvm_pkg;
  // Control sequencer states
  typedef enum logic [2:0] {
    S_IDLE, S_RD_WAIT, S_RD_SLOT, S_EE_WRITE, S_PM_SETUP, S_PM_ERASE
  } nvm_state_t;
  // Unlock sequence progress
  typedef enum logic [1:0] {UL_IDLE, UL_HALF, UL_ARMED} nvm_unlock_t;
  // Control register bits
  typedef struct packed {
    logic pgd;
    logic write_enable_bit;
    logic wr;
    logic rd;
  } nvm_ctl_t;
  // Requests toward the memory arrays
  typedef struct packed {
    logic        ee_wr;
    logic        ee_rd;
    logic        pm_rd;
    logic        pm_commit;
    logic [12:0] addr;
    logic [13:0] data;
  } nvm_mem_req_t;
  // Eight-word program write buffer
  typedef logic [7:0][13:0] nvm_pm_buf_t;
endpackage : nvm_pkg

// file: rtl/nvm_self_write.sv
// Self-write controller for data EEPROM and program flash
//
// Strobed register access and the register offsets were chosen for this implementation.
`timescale 1ns/10ps
`include "nvm_defines.svh"
module nvm_self_write #(
  parameter int P_EE_WRITE_CYC = `NVM_EE_WRITE_TIME_US * `NVM_CLK_MHZ,
  parameter int P_ERASE_CYC    = `NVM_ERASE_TIME_US * `NVM_CLK_MHZ,
  parameter bit P_PGM_WRITE_EN = 1'b1
) (
  input  wire logic                 i_ref_clk,
  input  wire logic                 i_reset,
  input  wire logic                 i_ce,
  input  wire logic [2:0]           i_addr,
  input  wire logic [7:0]           i_wdata,
  input  wire logic                 i_wr,
  input  wire logic                 i_rd,
  output logic      [7:0]           o_rdata,
  input  wire logic [1:0]           i_wrt_protect_cfg,
  input  wire logic [7:0]           i_ee_rdata,
  input  wire logic [13:0]          i_pm_rdata,
  output nvm_pkg::nvm_mem_req_t     o_mem,
  output nvm_pkg::nvm_pm_buf_t      o_pm_buf,
  output logic                      o_cpu_stall,
  output logic                      o_cpu_squash,
  output logic                      o_write_done_flag
);
  // ----------------------------------------------------------------
  // Helper functions
  // ----------------------------------------------------------------
  // True when a program word lies in a self-write protected segment
  function automatic logic prot_hit(input logic [1:0]  cfg,
                                    input logic [12:0] a);
    logic hit;
    case (cfg)
      2'b11:   hit = 1'b0;
      2'b10:   hit = (a < `NVM_PROT_LIMIT_LOW);
      2'b01:   hit = (a < `NVM_PROT_LIMIT_MID);
      default: hit = 1'b1;
    endcase
    return hit;
  endfunction : prot_hit

  // Register write decode
  function automatic logic wr_hit(input logic       stb,
                                  input logic [2:0] a,
                                  input logic [2:0] off);
    return stb && (a == off);
  endfunction : wr_hit

  // ----------------------------------------------------------------
  // State
  // ----------------------------------------------------------------
  logic [7:0]                     addr_lo_q;  // Low address byte
  logic [4:0]                     addr_hi_q;  // High address bits
  logic [7:0]                     data_lo_q;  // Low data byte
  logic [5:0]                     data_hi_q;  // High data bits
  nvm_pkg::nvm_ctl_t              ctl_q;      // Control bits
  logic                           done_q;     // Write done flag
  nvm_pkg::nvm_state_t            state_q;    // Sequencer
  nvm_pkg::nvm_unlock_t           ul_q;       // Unlock progress
  logic [`NVM_CNT_W-1:0]          cnt_q;      // Cycle down counter
  nvm_pkg::nvm_pm_buf_t           buf_q;      // Program buffer
  logic [7:0]                     rdata_q;    // Registered read data

  // ----------------------------------------------------------------
  // Decode
  // ----------------------------------------------------------------
  wire        bus_we    = i_ce && i_wr;
  wire        we_alo    = wr_hit(bus_we, i_addr, `NVM_OFF_ADDR_LOW);
  wire        we_ahi    = wr_hit(bus_we, i_addr, `NVM_OFF_ADDR_HIGH);
  wire        we_dlo    = wr_hit(bus_we, i_addr, `NVM_OFF_DATA_LOW);
  wire        we_dhi    = wr_hit(bus_we, i_addr, `NVM_OFF_DATA_HIGH);
  wire        we_ctl    = wr_hit(bus_we, i_addr, `NVM_OFF_CONTROL);
  wire        we_ul     = wr_hit(bus_we, i_addr, `NVM_OFF_UNLOCK);
  wire        we_st     = wr_hit(bus_we, i_addr, `NVM_OFF_STATUS);
  wire [12:0] word_addr = {addr_hi_q, addr_lo_q};
  wire        idle      = (state_q == nvm_pkg::S_IDLE);
  wire        cnt_zero  = (cnt_q == '0);
  wire        last_word = (addr_lo_q[2:0] == `NVM_BLOCK_LAST);
  // Software tries to set the start bit
  wire        wr_try    = we_ctl && i_wdata[`NVM_BIT_WR] && !ctl_q.wr;
  // Start accepted only armed, enabled and with nothing in flight
  wire        wr_go     = wr_try && (ul_q == nvm_pkg::UL_ARMED) &&
                          ctl_q.write_enable_bit && idle && !ctl_q.rd;
  // Program start refused: variant disables it or segment protected
  wire        pm_refuse = ctl_q.pgd &&
                          (!P_PGM_WRITE_EN ||
                           prot_hit(i_wrt_protect_cfg, word_addr));
  wire        wr_start  = wr_go && !pm_refuse;
  // Start and read in one write: start wins, else rd would never clear
  wire        rd_start  = we_ctl && i_wdata[`NVM_BIT_RD] && !ctl_q.rd &&
                          idle && !wr_start;
  wire        in_slot   = (state_q == nvm_pkg::S_RD_SLOT);
  wire [13:0] rd_word   = ctl_q.pgd ? i_pm_rdata :
                          {data_hi_q, i_ee_rdata};
  wire        ee_end    = (state_q == nvm_pkg::S_EE_WRITE) && cnt_zero;
  wire        pm_end    = (state_q == nvm_pkg::S_PM_ERASE) && cnt_zero;
  wire        setup_end = (state_q == nvm_pkg::S_PM_SETUP) && cnt_zero;
  wire        wr_end    = ee_end || pm_end || (setup_end && !last_word);

  // ----------------------------------------------------------------
  // Read mux
  // ----------------------------------------------------------------
  logic [7:0] rmux;
  always_comb begin
    rmux = `NVM_RST_BYTE;
    case (i_addr)
      `NVM_OFF_ADDR_LOW:  rmux = addr_lo_q;
      `NVM_OFF_ADDR_HIGH: rmux = {3'h0, addr_hi_q};
      `NVM_OFF_DATA_LOW:  rmux = data_lo_q;
      `NVM_OFF_DATA_HIGH: rmux = {2'h0, data_hi_q};
      `NVM_OFF_CONTROL:   rmux = {ctl_q.pgd, 4'h0, ctl_q.write_enable_bit,
                                  ctl_q.wr, ctl_q.rd};
      `NVM_OFF_STATUS:    rmux = {7'h00, done_q};
      default:            rmux = `NVM_RST_BYTE; // Unlock port reads 0
    endcase
  end

  // ----------------------------------------------------------------
  // Address and data registers
  // ----------------------------------------------------------------
  // A read landing wins over a software write in the same cycle
  always_ff @(posedge i_ref_clk) begin
    if (i_reset) begin
      addr_lo_q <= 8'h00;
      addr_hi_q <= 5'h00;
      data_lo_q <= 8'h00;
      data_hi_q <= 6'h00;
    end else if (i_ce) begin
      if (we_alo) addr_lo_q <= i_wdata;
      if (we_ahi) addr_hi_q <= i_wdata[4:0];
      if (in_slot) begin
        data_lo_q <= rd_word[7:0];
        data_hi_q <= rd_word[13:8];
      end else begin
        if (we_dlo) data_lo_q <= i_wdata;
        if (we_dhi) data_hi_q <= i_wdata[5:0];
      end
    end
  end

  // ----------------------------------------------------------------
  // Control bits and done flag
  // ----------------------------------------------------------------
  always_ff @(posedge i_ref_clk) begin
    if (i_reset) begin
      ctl_q  <= '0;
      done_q <= 1'b0;
    end else if (i_ce) begin
      if (we_ctl) begin
        // Select and enable follow software only
        ctl_q.pgd  <= i_wdata[`NVM_BIT_PGD];
        ctl_q.write_enable_bit <= i_wdata[`NVM_BIT_WRITE_ENABLE_BIT];
      end
      // Start and read bits: set by software, cleared by hardware
      if (wr_start) ctl_q.wr <= 1'b1;
      else if (wr_end) ctl_q.wr <= 1'b0;
      if (rd_start) ctl_q.rd <= 1'b1;
      else if (in_slot) ctl_q.rd <= 1'b0;
      // Hardware set beats a software clear in the same cycle
      if (ee_end) done_q <= 1'b1;
      else if (we_st && !i_wdata[`NVM_BIT_DONE]) done_q <= 1'b0;
    end
  end

  // ----------------------------------------------------------------
  // Unlock sequence
  // ----------------------------------------------------------------
  // Any write that is not the next expected step disarms
  always_ff @(posedge i_ref_clk) begin
    if (i_reset) begin
      ul_q <= nvm_pkg::UL_IDLE;
    end else if (bus_we) begin
      if (we_ul && i_wdata == `NVM_KEY_FIRST)
        ul_q <= nvm_pkg::UL_HALF;
      else if (we_ul && i_wdata == `NVM_KEY_SECOND &&
               ul_q == nvm_pkg::UL_HALF)
        ul_q <= nvm_pkg::UL_ARMED;
      else
        ul_q <= nvm_pkg::UL_IDLE;
    end
  end

  // ----------------------------------------------------------------
  // Sequencer
  // ----------------------------------------------------------------
  always_ff @(posedge i_ref_clk) begin
    if (i_reset) begin
      state_q <= nvm_pkg::S_IDLE;
      cnt_q   <= '0;
    end else if (i_ce) begin
      case (state_q)
        nvm_pkg::S_IDLE: begin
          if (wr_start && !ctl_q.pgd) begin
            state_q <= nvm_pkg::S_EE_WRITE;
            cnt_q   <= `NVM_CNT_W'(P_EE_WRITE_CYC - 1);
          end else if (wr_start) begin
            state_q <= nvm_pkg::S_PM_SETUP;
            cnt_q   <= `NVM_SETUP_CYC - `NVM_CNT_W'(1);
          end else if (rd_start && i_wdata[`NVM_BIT_PGD]) begin
            state_q <= nvm_pkg::S_RD_WAIT;
          end else if (rd_start) begin
            state_q <= nvm_pkg::S_RD_SLOT;
          end
        end
        // First instruction after the read request runs normally
        nvm_pkg::S_RD_WAIT: state_q <= nvm_pkg::S_RD_SLOT;
        nvm_pkg::S_RD_SLOT: state_q <= nvm_pkg::S_IDLE;
        // Enable bit is not looked at once running
        nvm_pkg::S_EE_WRITE: begin
          if (cnt_zero) state_q <= nvm_pkg::S_IDLE;
          else          cnt_q   <= cnt_q - `NVM_CNT_W'(1);
        end
        nvm_pkg::S_PM_SETUP: begin
          if (cnt_zero && last_word) begin
            state_q <= nvm_pkg::S_PM_ERASE;
            cnt_q   <= `NVM_CNT_W'(P_ERASE_CYC - 1);
          end else if (cnt_zero) begin
            state_q <= nvm_pkg::S_IDLE;
          end else begin
            cnt_q <= cnt_q - `NVM_CNT_W'(1);
          end
        end
        nvm_pkg::S_PM_ERASE: begin
          if (cnt_zero) state_q <= nvm_pkg::S_IDLE;
          else          cnt_q   <= cnt_q - `NVM_CNT_W'(1);
        end
        default: state_q <= nvm_pkg::S_IDLE;
      endcase
    end
  end

  // ----------------------------------------------------------------
  // Program buffer and read data register
  // ----------------------------------------------------------------
  // Slot chosen by the low address bits keeps blocks aligned
  always_ff @(posedge i_ref_clk) begin
    if (i_reset) begin
      buf_q   <= '0;
      rdata_q <= `NVM_RST_BYTE;
    end else if (i_ce) begin
      if (wr_start && ctl_q.pgd)
        buf_q[addr_lo_q[2:0]] <= {data_hi_q, data_lo_q};
      if (i_rd) rdata_q <= rmux;
    end
  end

  // ----------------------------------------------------------------
  // Outputs
  // ----------------------------------------------------------------
  // Erase covers the sixteen-word region holding this block
  assign o_mem.ee_wr     = i_ce && wr_start && !ctl_q.pgd;
  assign o_mem.ee_rd     = i_ce && in_slot && !ctl_q.pgd;
  assign o_mem.pm_rd     = i_ce && in_slot && ctl_q.pgd;
  assign o_mem.pm_commit = i_ce && pm_end;
  assign o_mem.addr      = word_addr;
  assign o_mem.data      = {data_hi_q, data_lo_q};
  assign o_pm_buf        = buf_q;
  assign o_rdata         = rdata_q;
  // Clocks keep running; only the core is held
  assign o_cpu_stall     = (state_q == nvm_pkg::S_PM_ERASE);
  assign o_cpu_squash    = in_slot && ctl_q.pgd;
  assign o_write_done_flag = done_q;

  // ----------------------------------------------------------------
  // Assertions
  // ----------------------------------------------------------------
  sequence s_pm_rd_req;
    i_ce && rd_start && i_wdata[`NVM_BIT_PGD] && !i_reset;
  endsequence
  sequence s_one_run;
    i_ce [*1];
  endsequence

  property p_unlock_needed;
    @(posedge i_ref_clk) disable iff (i_reset)
    i_ce && wr_try && ul_q != nvm_pkg::UL_ARMED |=> !ctl_q.wr;
  endproperty
  a_unlock_needed: assert property (p_unlock_needed)
    else $error("start accepted without unlock");

  property p_write_enable_bit_gate;
    @(posedge i_ref_clk) disable iff (i_reset)
    i_ce && wr_try && !ctl_q.write_enable_bit |=> !ctl_q.wr;
  endproperty
  a_write_enable_bit_gate: assert property (p_write_enable_bit_gate)
    else $error("start accepted with enable clear");

  property p_write_enable_bit_kept;
    @(posedge i_ref_clk) disable iff (i_reset)
    !we_ctl |=> $stable(ctl_q.write_enable_bit);
  endproperty
  a_write_enable_bit_kept: assert property (p_write_enable_bit_kept)
    else $error("enable bit changed by hardware");

  property p_ee_runs;
    @(posedge i_ref_clk) disable iff (i_reset)
    i_ce && state_q == nvm_pkg::S_EE_WRITE && !cnt_zero
      |=> state_q == nvm_pkg::S_EE_WRITE && ctl_q.wr;
  endproperty
  a_ee_runs: assert property (p_ee_runs)
    else $error("data write ended early");

  property p_ee_done;
    @(posedge i_ref_clk) disable iff (i_reset)
    i_ce && ee_end |=> !ctl_q.wr && done_q;
  endproperty
  a_ee_done: assert property (p_ee_done)
    else $error("write end did not flag done");

  property p_pm_slot;
    @(posedge i_ref_clk) disable iff (i_reset)
    s_pm_rd_req ##1 s_one_run |=> o_cpu_squash && o_mem.pm_rd;
  endproperty
  a_pm_slot: assert property (p_pm_slot)
    else $error("program read not in second cycle");

  property p_rd_data;
    @(posedge i_ref_clk) disable iff (i_reset)
    i_ce && in_slot |=> data_lo_q == $past(rd_word[7:0]) &&
                        data_hi_q == $past(rd_word[13:8]);
  endproperty
  a_rd_data: assert property (p_rd_data)
    else $error("read data not captured");

  property p_protect;
    @(posedge i_ref_clk) disable iff (i_reset)
    i_ce && wr_try && ctl_q.pgd &&
      prot_hit(i_wrt_protect_cfg, word_addr) |=> !ctl_q.wr;
  endproperty
  a_protect: assert property (p_protect)
    else $error("protected program word started");

  property p_commit_last;
    @(posedge i_ref_clk) disable iff (i_reset)
    o_mem.pm_commit |-> last_word && o_cpu_stall;
  endproperty
  a_commit_last: assert property (p_commit_last)
    else $error("commit from a non-last word");

  property p_reset_pgd;
    @(posedge i_ref_clk) disable iff (i_reset)
    $past(i_reset) |-> !ctl_q.pgd && idle;
  endproperty
  a_reset_pgd: assert property (p_reset_pgd)
    else $error("program select set after reset");
endmodule : nvm_self_write

// file: test/nvm_array_model.sv
// Array model: data EEPROM bytes and program flash words
`timescale 1ns/10ps
module nvm_array_model (
  input  wire logic                  i_ref_clk,
  input  wire nvm_pkg::nvm_mem_req_t i_mem,
  input  wire nvm_pkg::nvm_pm_buf_t  i_pm_buf,
  output logic [7:0]                 o_ee_rdata,
  output logic [13:0]                o_pm_rdata
);
  logic [7:0]  ee_q [256];   // Data bytes
  logic [13:0] pm_q [8192];  // Program words
  // ----------------------------------------------------------------
  // Preset contents with a known pattern
  // ----------------------------------------------------------------
  initial begin
    for (int i = 0; i < 8192; i++) begin
      pm_q[i] = 14'(i) ^ 14'h1555;
      if (i < 256) begin
        ee_q[i] = 8'(i) ^ 8'hA5;
      end
    end
  end
  // ----------------------------------------------------------------
  // Read ports: outside a read the lines show inverted junk, so a
  // late sample can never pass by luck
  // ----------------------------------------------------------------
  assign o_ee_rdata = i_mem.ee_rd ? ee_q[i_mem.addr[7:0]]
                                  : ~ee_q[i_mem.addr[7:0]];
  assign o_pm_rdata = i_mem.pm_rd ? pm_q[i_mem.addr] : ~pm_q[i_mem.addr];
  // ----------------------------------------------------------------
  // Writes: byte write, or sixteen-word erase plus eight-word program
  // ----------------------------------------------------------------
  always @(posedge i_ref_clk) begin
    if (i_mem.ee_wr) begin
      ee_q[i_mem.addr[7:0]] <= i_mem.data[7:0];
    end
    if (i_mem.pm_commit) begin
      // Aligned region only, never across a boundary
      for (int k = 0; k < 16; k++) begin
        pm_q[{i_mem.addr[12:4], 4'(k)}] <= (k[3] == i_mem.addr[3])
          ? i_pm_buf[k[2:0]] : 14'h3FFF;
      end
    end
  end
endmodule : nvm_array_model

// file: test/nvm_self_write_controller_test.sv
// Self-checking testbench of the nonvolatile self-write controller
`timescale 1ns/10ps
module nvm_self_write_controller_test;
  localparam int LP_ERASE = 8;            // Shortened erase time
  logic                  ref_clk = 1'b0;  // 125 MHz clock
  logic                  reset   = 1'b1;  // Synchronous reset
  logic [2:0]            addr    = 3'h0;  // Register index
  logic [7:0]            wdata   = 8'h00; // Register write data
  logic                  wr      = 1'b0;  // Write strobe
  logic                  rd      = 1'b0;  // Read strobe
  logic [1:0]            prot    = 2'h3;  // Protection config
  logic [7:0]            rdata, ee_rdata;
  logic [13:0]           pm_rdata;
  nvm_pkg::nvm_mem_req_t mem;
  nvm_pkg::nvm_pm_buf_t  pm_buf;
  logic                  stall, squash, done_flag;
  int                    bad_count  = 0;
  int                    n_compared = 0;
  int                    n_ee_wr = 0, n_commit = 0, n_stall = 0;
  logic [12:0]           commit_addr = 13'h0000;

  always #4 ref_clk = ~ref_clk;

  nvm_self_write #(.P_EE_WRITE_CYC(16), .P_ERASE_CYC(LP_ERASE),
    .P_PGM_WRITE_EN(1'b1)) uut (
    .i_ref_clk(ref_clk), .i_reset(reset), .i_ce(1'b1), .i_addr(addr),
    .i_wdata(wdata), .i_wr(wr), .i_rd(rd), .o_rdata(rdata),
    .i_wrt_protect_cfg(prot), .i_ee_rdata(ee_rdata),
    .i_pm_rdata(pm_rdata), .o_mem(mem), .o_pm_buf(pm_buf),
    .o_cpu_stall(stall), .o_cpu_squash(squash),
    .o_write_done_flag(done_flag));

  nvm_array_model array (.i_ref_clk(ref_clk), .i_mem(mem),
    .i_pm_buf(pm_buf), .o_ee_rdata(ee_rdata), .o_pm_rdata(pm_rdata));

  // ----------------------------------------------------------------
  // Event counters seen at the memory side
  // ----------------------------------------------------------------
  always @(posedge ref_clk) begin
    if (mem.ee_wr === 1'b1) n_ee_wr <= n_ee_wr + 1;
    if (stall === 1'b1) n_stall <= n_stall + 1;
    if (mem.pm_commit === 1'b1) begin
      n_commit    <= n_commit + 1;
      commit_addr <= mem.addr;
    end
  end
  // ----------------------------------------------------------------
  // Helpers: compare, verdict, register bus
  // ----------------------------------------------------------------
  task automatic chk(input logic [15:0] got, input logic [15:0] exp);
    n_compared++;
    if (got !== exp) begin
      bad_count++;
      $display("ERROR %0t got %h expected %h", $time, got, exp);
    end
  endtask : chk
  task automatic end_of_test();
    if (bad_count == 0 && n_compared > 0) begin
      $display("Test passed");
    end else begin
      $display("Test failed");
    end
    $finish;
  endtask : end_of_test
  task automatic reg_wr(input logic [2:0] a, input logic [7:0] d);
    @(posedge ref_clk);
    addr  <= a;
    wdata <= d;
    wr    <= 1'b1;
    @(posedge ref_clk);
    wr    <= 1'b0;
  endtask : reg_wr
  task automatic reg_rd(input logic [2:0] a, output logic [7:0] d);
    @(posedge ref_clk);
    addr <= a;
    rd   <= 1'b1;
    @(posedge ref_clk);
    rd   <= 1'b0;
    #1;
    d = rdata;
  endtask : reg_rd
  // Unlock pair then the control write
  task automatic unlock_start(input logic [7:0] ctl);
    reg_wr(3'h5, 8'h55); // Nothing interleaved until start
    reg_wr(3'h5, 8'hAA);
    reg_wr(3'h4, ctl);
  endtask : unlock_start
  // Poll until the write bit drops; a hang ends the run as a failure
  task automatic wait_idle();
    logic [7:0] v;
    for (int i = 0; i < 40; i++) begin
      reg_rd(3'h4, v);
      if (v[1] === 1'b0) return;
    end
    bad_count++;
    end_of_test();
  endtask : wait_idle
  // ----------------------------------------------------------------
  // Scenarios
  // ----------------------------------------------------------------
  task automatic t_reset();
    logic [7:0] v;
    for (int a = 0; a < 8; a++) begin
      reg_rd(a[2:0], v);
      chk(16'(v), 16'h0000);
    end
  endtask : t_reset
  // Byte write; drop clears enable and tries to clear wr mid-cycle
  task automatic t_ee_write(input logic [7:0] a, d, input bit drop);
    logic [7:0] v;
    int         n0;
    n0 = n_ee_wr;
    reg_wr(3'h0, a);
    reg_wr(3'h2, d);
    reg_wr(3'h4, 8'h04);
    unlock_start(8'h06);
    reg_rd(3'h4, v);
    chk(16'(v), 16'h0006);
    if (drop) reg_wr(3'h4, 8'h00);
    reg_rd(3'h4, v);
    chk(16'(v), drop ? 16'h0002 : 16'h0006);
    reg_rd(3'h6, v);
    chk(16'(v[0]), 16'h0000);
    wait_idle();
    chk(16'(n_ee_wr - n0), 16'h0001);
    reg_rd(3'h4, v);
    chk(16'(v), drop ? 16'h0000 : 16'h0004);
    repeat (5) @(posedge ref_clk);
    reg_rd(3'h6, v);
    chk(16'(v[0]), 16'h0001);
    chk(16'(done_flag), 16'h0001);
    reg_wr(3'h6, 8'h00);
    reg_rd(3'h6, v);
    chk(16'(v[0]), 16'h0000);
    chk(16'(done_flag), 16'h0000);
  endtask : t_ee_write
  task automatic t_ee_read(input logic [7:0] a, exp);
    logic [7:0] v;
    reg_wr(3'h0, a);
    reg_wr(3'h2, ~exp); // Stale value the read must replace
    reg_wr(3'h4, 8'h01);
    @(posedge ref_clk);
    reg_rd(3'h2, v);
    chk(16'(v), 16'(exp));
    reg_rd(3'h4, v);
    chk(16'(v[0]), 16'h0000);
    repeat (4) @(posedge ref_clk);
    reg_rd(3'h2, v);
    chk(16'(v), 16'(exp));
  endtask : t_ee_read
  // Broken unlock sequences and a missing enable must start nothing
  task automatic t_bad_start();
    logic [7:0] v;
    int         n0;
    for (int k = 0; k < 5; k++) begin
      n0 = n_ee_wr;
      reg_wr(3'h4, (k == 4) ? 8'h00 : 8'h04);
      case (k)
        1: reg_wr(3'h5, 8'h55);
        2: begin
          reg_wr(3'h5, 8'hAA);
          reg_wr(3'h5, 8'h55);
        end
        3: begin
          reg_wr(3'h5, 8'h55);
          reg_wr(3'h0, 8'h10);
          reg_wr(3'h5, 8'hAA);
        end
        4: begin
          reg_wr(3'h5, 8'h55);
          reg_wr(3'h5, 8'hAA);
        end
        default: ;
      endcase
      reg_wr(3'h4, (k == 4) ? 8'h02 : 8'h06);
      reg_rd(3'h4, v);
      chk(16'(v[1]), 16'h0000);
      chk(16'(n_ee_wr - n0), 16'h0000);
    end
  endtask : t_bad_start
  // Program read: second cycle is read and squashed
  task automatic t_pm_read(input logic [12:0] a, input logic [13:0] exp);
    logic [7:0] v;
    reg_wr(3'h1, {3'h0, a[12:8]});
    reg_wr(3'h0, a[7:0]);
    reg_wr(3'h4, 8'h81);
    #1;
    chk(16'(squash), 16'h0000);
    @(posedge ref_clk); // Second slot is squashed and carries the program read request
    #1;
    chk(16'({squash, mem.pm_rd}), 16'h0003);
    reg_rd(3'h2, v);
    chk(16'(v), 16'(exp[7:0]));
    reg_rd(3'h3, v);
    chk(16'(v), 16'(exp[13:8]));
  endtask : t_pm_read
  // Eight-word block under a protection code; open says it may commit
  task automatic t_pm_block(input logic [12:0] base, input logic [1:0] p,
                            input bit open);
    logic [13:0] w;
    int          c0, s0;
    @(posedge ref_clk);
    prot <= p;
    c0 = n_commit;
    for (int i = 0; i < 8; i++) begin // All eight slots written; buffer filled only when open
      w  = 14'h2A50 + 14'(i);
      s0 = n_stall;
      reg_wr(3'h1, {3'h0, base[12:8]});
      reg_wr(3'h0, base[7:0] | 8'(i));
      reg_wr(3'h2, w[7:0]);
      reg_wr(3'h3, {2'h0, w[13:8]});
      reg_wr(3'h4, 8'h84);
      unlock_start(8'h86);
      @(posedge ref_clk);
      #1;
      if (open) chk(16'(pm_buf[i]), 16'(w));
      chk(16'(stall), 16'h0000);
      @(posedge ref_clk);
      #1;
      chk(16'(stall), 16'(i == 7 && open));
      wait_idle();
      chk(16'(n_stall - s0),
          (i == 7 && open) ? 16'(LP_ERASE) : 16'h0);
    end
    chk(16'(n_commit - c0), 16'(open));
    if (open) chk(16'(commit_addr[12:3]), 16'(base[12:3]));
  endtask : t_pm_block
  // ----------------------------------------------------------------
  // Main sequence
  // ----------------------------------------------------------------
  initial begin
    repeat (6) @(posedge ref_clk);
    reset <= 1'b0;
    t_reset();
    t_ee_write(8'h3C, 8'h5E, 1'b0);
    t_ee_read(8'h3C, 8'h5E);
    t_ee_write(8'hFF, 8'h81, 1'b1);
    t_ee_read(8'hFF, 8'h81);
    t_bad_start();
    t_ee_read(8'h10, 8'hB5);
    t_pm_read(13'h1234, 14'h0761);
    t_pm_block(13'h0200, 2'h3, 1'b1);
    t_pm_read(13'h0202, 14'h2A52);
    t_pm_read(13'h020A, 14'h3FFF);
    t_pm_block(13'h0208, 2'h3, 1'b1);
    t_pm_read(13'h020A, 14'h2A52);
    t_pm_block(13'h0040, 2'h2, 1'b0);
    t_pm_block(13'h0300, 2'h1, 1'b0);
    t_pm_block(13'h0F00, 2'h0, 1'b0);
    t_pm_read(13'h0307, 14'h1652);
    end_of_test();
  end
endmodule : nvm_self_write_controller_test
